// [hw/eep_ctrl.sv]
// Two-wire serial EEPROM slave: framing, addressing, page buffer, program timer, AXI4-Lite status.
// Assumes scl/sda/straps are asynchronous pins and the cell array answers reads one cycle after arr_req.
`default_nettype none

// Functional notes
// - Write opens with START, device code, chip address, direction low, then word address.
// - Addressed device acknowledges on the ninth clock after the control byte.
// - Word address loads pointer low byte; four-kilobit uses chip bit zero as ninth.
// - Each written byte is acknowledged and stored in the page buffer until STOP.
// - STOP after a write starts the self-timed program of all buffered bytes.
// - Page buffer holds two bytes, or eight on the four-kilobit variant.
// - Two-byte variants refuse a third data byte and abort the write.
// - Eight-byte page increments only low three pointer bits, rolling over.
// - STOP after the first data byte programs that single byte.
// - Program cycle lasts one millisecond per buffered byte.
// - Write control byte is not acknowledged while programming, acknowledged after.
// - With write-lock high, protected upper-half first data byte is refused, nothing programmed.
// - Write-lock has no effect on the one-kilobit variant.
// - Read shifts out byte at pointer, increments, continues while master acknowledges.
// - Read without pointer write returns data from the current pointer.
// - Pointer wraps inside its 256-byte block, never crossing blocks.
// - Respond only when chip bits match straps; four-kilobit ignores bit zero.
// - Control byte acknowledged only on address match and no program running.
// - On master not-acknowledge the data line is released high.
// - Four-kilobit chip bit zero selects upper or lower 256-byte block.
module eep_ctrl
  import eep_pkg::*;
#(
  parameter eep_variant_t VARIANT  = EEP_4K,
  parameter logic [3:0]   DEV_CODE = 4'h5,          // Arbitrary value
  parameter int unsigned  PROG_CYC = PROG_BYTE_CYC
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  input  wire logic         chip_sel_bit0,
  input  wire logic         chip_sel_bit1,
  input  wire logic         chip_sel_bit2,
  input  wire logic         write_lock,
  output eep_arr_req_t      arr_req,
  input  wire logic [7:0]   arr_rdata,
  input  wire eep_axi_req_t s_axi_req,
  output eep_axi_rsp_t      s_axi_rsp
);

  localparam logic             IS4K     = (VARIANT == EEP_4K);
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(PROG_CYC - 1);

  eep_state_t st_r;
  eep_state_t st_nxt;

  // Upper-half protection test per variant
  function automatic logic prot_hit(input logic [8:0] p, input logic wl);
    case (VARIANT)
      EEP_2K:  prot_hit = wl & p[7];
      EEP_4K:  prot_hit = wl & p[8];
      default: prot_hit = 1'b0;
    endcase
  endfunction : prot_hit

  // Pointer step that stays in its 256-byte block
  function automatic logic [8:0] ptr_step(input logic [8:0] p);
    ptr_step = {p[8], p[7:0] + 8'h01};
  endfunction : ptr_step

  // Register decode, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] a, input logic wr);
    reg_hit = (a == REG_CTRL) || (!wr && a == REG_STATUS);
  endfunction : reg_hit

  // Bus conditions seen on the synchronised pins
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic sel_ok;
  assign scl_s    = st_r.scl_sy[1];
  assign sda_s    = st_r.sda_sy[1];
  assign scl_rise = scl_s & ~st_r.scl_q;
  assign scl_fall = ~scl_s & st_r.scl_q;
  assign start_ev = scl_s & st_r.scl_q & st_r.sda_q & ~sda_s;
  assign stop_ev  = scl_s & st_r.scl_q & ~st_r.sda_q & sda_s;
  assign sel_ok   = (st_r.shreg[3] == st_r.cs_sy1[2]) && (st_r.shreg[2] == st_r.cs_sy1[1])
                    && (IS4K || st_r.shreg[1] == st_r.cs_sy1[0]);

  // Page slot for the incoming data byte
  logic [2:0] wr_slot;
  assign wr_slot = IS4K ? st_r.ptr[2:0] : {2'b00, st_r.nbytes[0]};

  // Read byte load, at end of control ack or after master ack
  logic ld_rd;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt        = st_r;
    ld_rd         = 1'b0;
    st_nxt.scl_sy = {st_r.scl_sy[0], scl_i};
    st_nxt.sda_sy = {st_r.sda_sy[0], sda_i};
    st_nxt.wl_sy  = {st_r.wl_sy[0], write_lock};
    st_nxt.cs_sy0 = {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
    st_nxt.cs_sy1 = st_r.cs_sy0;
    st_nxt.scl_q  = scl_s;
    st_nxt.sda_q  = sda_s;
    st_nxt.arr.we = 1'b0;
    st_nxt.sda_o  = 1'b0;

    // Framing: START/STOP preempt any byte in flight
    if (start_ev) begin
      st_nxt.ser    = SER_RX;
      st_nxt.kind   = K_CTRL;
      st_nxt.cnt    = 4'h0;
      st_nxt.sda_oe = 1'b0;
      st_nxt.nbytes = 4'h0;
      st_nxt.abort  = 1'b0;
      if (!st_r.busy) begin
        st_nxt.buf_vld = 8'h00;                      // Unfinished write is dropped
      end
    end else if (stop_ev) begin
      st_nxt.ser    = SER_IDLE;
      st_nxt.sda_oe = 1'b0;
      if (st_r.kind == K_DATA && st_r.nbytes != 4'h0 && !st_r.abort && !st_r.busy) begin
        st_nxt.busy = 1'b1;
        st_nxt.slot = 3'h0;
        st_nxt.tmr  = '0;
      end
    end else begin
      case (st_r.ser)
        SER_RX: begin
          if (scl_rise) begin
            st_nxt.shreg = {st_r.shreg[6:0], sda_s};
            st_nxt.cnt   = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == BITS_BYTE) begin
            st_nxt.ser    = SER_ACK;
            st_nxt.sda_oe = 1'b1;
            case (st_r.kind)
              K_CTRL: begin
                if (st_r.shreg[7:4] == DEV_CODE && sel_ok && st_r.ctrl_en && !st_r.busy) begin
                  st_nxt.kind = st_r.shreg[0] ? K_READ : K_WADDR;
                  if (IS4K) begin
                    st_nxt.ptr[8] = st_r.shreg[1];
                  end
                end else begin
                  st_nxt.ser    = SER_IDLE;
                  st_nxt.sda_oe = 1'b0;
                end
              end
              K_WADDR: begin
                st_nxt.ptr[7:0] = st_r.shreg;
                st_nxt.kind     = K_DATA;
                st_nxt.nbytes   = 4'h0;
              end
              K_DATA: begin
                if ((st_r.nbytes == 4'h0 && prot_hit(st_r.ptr, st_r.wl_sy[1]))
                    || (!IS4K && st_r.nbytes == PAGE_SMALL)) begin
                  st_nxt.abort  = 1'b1;
                  st_nxt.ser    = SER_IDLE;
                  st_nxt.sda_oe = 1'b0;
                end else begin
                  st_nxt.buf_data[wr_slot] = st_r.shreg;
                  st_nxt.buf_addr[wr_slot] = st_r.ptr;
                  st_nxt.buf_vld[wr_slot]  = 1'b1;
                  if (st_r.nbytes != (IS4K ? PAGE_LARGE : PAGE_SMALL)) begin
                    st_nxt.nbytes = st_r.nbytes + 4'h1;
                  end
                  st_nxt.ptr = IS4K ? {st_r.ptr[8:3], st_r.ptr[2:0] + 3'h1}
                                    : ptr_step(st_r.ptr);
                end
              end
              default: begin
                st_nxt.ser    = SER_IDLE;
                st_nxt.sda_oe = 1'b0;
              end
            endcase
          end
        end
        SER_ACK: begin
          if (scl_fall) begin
            st_nxt.sda_oe = 1'b0;
            st_nxt.cnt    = 4'h0;
            st_nxt.ser    = SER_RX;
            ld_rd         = (st_r.kind == K_READ);
          end
        end
        SER_TX: begin
          if (scl_fall) begin
            if (st_r.cnt == BITS_BYTE) begin
              st_nxt.sda_oe = 1'b0;                  // Free the line for master ack
              st_nxt.ser    = SER_TXACK;
            end else begin
              st_nxt.sda_oe = ~st_r.shreg[7];
              st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
              st_nxt.cnt    = st_r.cnt + 4'h1;
            end
          end
        end
        SER_TXACK: begin
          if (scl_rise && sda_s) begin
            st_nxt.ser = SER_IDLE;
          end else if (scl_fall) begin
            ld_rd = 1'b1;
          end
        end
        default: begin
          st_nxt.ser = SER_IDLE;
        end
      endcase
    end

    // Read byte launch: first bit driven now, pointer moves on
    if (ld_rd) begin
      st_nxt.shreg  = {arr_rdata[6:0], 1'b0};
      st_nxt.sda_oe = ~arr_rdata[7];
      st_nxt.cnt    = 4'h1;
      st_nxt.ptr    = ptr_step(st_r.ptr);
      st_nxt.ser    = SER_TX;
    end

    // Self-timed program: one slot per millisecond, empty slots skipped
    if (st_r.busy) begin
      if (st_r.buf_vld[st_r.slot]) begin
        if (st_r.tmr == '0) begin
          st_nxt.arr.we    = 1'b1;
          st_nxt.arr.addr  = st_r.buf_addr[st_r.slot];
          st_nxt.arr.wdata = st_r.buf_data[st_r.slot];
        end
        st_nxt.tmr = st_r.tmr + TMR_W'(1);
      end
      if (!st_r.buf_vld[st_r.slot] || st_r.tmr == TMR_LAST) begin
        st_nxt.tmr                = '0;
        st_nxt.buf_vld[st_r.slot] = 1'b0;
        st_nxt.slot               = st_r.slot + 3'h1;
        if (st_r.slot == 3'h7) begin
          st_nxt.busy = 1'b0;
        end
      end
    end else begin
      st_nxt.arr.addr = st_r.ptr;                    // Array read follows the pointer
    end

    // AXI4-Lite write: address and data taken in either order
    if (st_r.axi.awready && s_axi_req.awvalid) begin
      st_nxt.aw_got      = 1'b1;
      st_nxt.awa         = s_axi_req.awaddr;
      st_nxt.axi.awready = 1'b0;
    end
    if (st_r.axi.wready && s_axi_req.wvalid) begin
      st_nxt.w_got      = 1'b1;
      st_nxt.wda        = s_axi_req.wdata;
      st_nxt.wst        = s_axi_req.wstrb;
      st_nxt.axi.wready = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got) begin
      st_nxt.aw_got     = 1'b0;
      st_nxt.w_got      = 1'b0;
      st_nxt.axi.bvalid = 1'b1;
      st_nxt.axi.bresp  = reg_hit(st_r.awa, 1'b1) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.awa == REG_CTRL && st_r.wst[0]) begin
        st_nxt.ctrl_en = st_r.wda[CTRL_EN_BIT];      // Gates the acknowledge of the control byte
      end
    end
    if (st_r.axi.bvalid && s_axi_req.bready) begin
      st_nxt.axi.bvalid  = 1'b0;
      st_nxt.axi.awready = 1'b1;
      st_nxt.axi.wready  = 1'b1;
    end

    // AXI4-Lite read: one outstanding, unmapped answers SLVERR with zero
    if (st_r.axi.arready && s_axi_req.arvalid) begin
      st_nxt.axi.arready = 1'b0;
      st_nxt.axi.rvalid  = 1'b1;
      st_nxt.axi.rresp   = reg_hit(s_axi_req.araddr, 1'b0) ? RESP_OKAY : RESP_SLVERR;
      st_nxt.axi.rdata   = 32'h0;
      if (s_axi_req.araddr == REG_CTRL) begin
        st_nxt.axi.rdata = 32'(st_r.ctrl_en) << CTRL_EN_BIT;
      end else if (s_axi_req.araddr == REG_STATUS) begin
        st_nxt.axi.rdata = (32'(st_r.busy) << STAT_BUSY_BIT) | (32'(st_r.ptr) << STAT_PTR_LSB)
                           | (32'(st_r.nbytes) << STAT_CNT_LSB);
      end
    end
    if (st_r.axi.rvalid && s_axi_req.rready) begin
      st_nxt.axi.rvalid  = 1'b0;
      st_nxt.axi.arready = 1'b1;
    end
  end

  // State register; handshake readies come up high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r             <= '0;
      st_r.ctrl_en     <= CTRL_EN_RST;
      st_r.axi.awready <= 1'b1;
      st_r.axi.wready  <= 1'b1;
      st_r.axi.arready <= 1'b1;
      st_r.scl_sy      <= 2'b11;                 // Idle bus level, no false edge after reset
      st_r.sda_sy      <= 2'b11;
      st_r.scl_q       <= 1'b1;
      st_r.sda_q       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign sda_o     = st_r.sda_o;
  assign sda_oe    = st_r.sda_oe;
  assign arr_req   = st_r.arr;
  assign s_axi_rsp = st_r.axi;

endmodule : eep_ctrl
`default_nettype wire

// [inc/eep_pkg.sv]
// Shared constants, types and carriers of the serial EEPROM slave controller.
// Assumes a single 20 MHz system clock; all pins arrive asynchronously.
`default_nettype none
package eep_pkg;

  // Timebase and self-timed program cycle
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned PROG_BYTE_NS  = 1000000;                        // 1 ms per programmed byte
  localparam int unsigned PROG_BYTE_CYC = PROG_BYTE_NS / CLK_PERIOD_NS;   // Longest time, rounds down
  localparam int unsigned TMR_W         = 24;

  // Page buffer sizes and bits per byte
  localparam logic [3:0] PAGE_SMALL = 4'h2;
  localparam logic [3:0] PAGE_LARGE = 4'h8;
  localparam logic [3:0] BITS_BYTE  = 4'h8;

  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_PTR_LSB  = 4;
  localparam int unsigned STAT_CNT_LSB  = 16;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {EEP_1K, EEP_2K, EEP_4K} eep_variant_t;
  typedef enum logic [2:0] {SER_IDLE, SER_RX, SER_ACK, SER_TX, SER_TXACK} eep_ser_t;
  typedef enum logic [1:0] {K_CTRL, K_WADDR, K_DATA, K_READ} eep_kind_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } eep_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } eep_axi_rsp_t;

  // Cell array port: write strobe and address/data
  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } eep_arr_req_t;

  typedef struct packed {
    logic [1:0]            scl_sy;
    logic [1:0]            sda_sy;
    logic [1:0]            wl_sy;
    logic [2:0]            cs_sy0;
    logic [2:0]            cs_sy1;
    logic                  scl_q;
    logic                  sda_q;
    eep_ser_t              ser;
    eep_kind_t             kind;
    logic [3:0]            cnt;
    logic [7:0]            shreg;
    logic [8:0]            ptr;
    logic [3:0]            nbytes;
    logic                  abort;
    logic                  sda_o;
    logic                  sda_oe;
    logic [7:0][7:0]       buf_data;
    logic [7:0][8:0]       buf_addr;
    logic [7:0]            buf_vld;
    logic                  busy;
    logic [2:0]            slot;
    logic [TMR_W-1:0]      tmr;
    eep_arr_req_t          arr;
    logic                  ctrl_en;
    eep_axi_rsp_t          axi;
    logic                  aw_got;
    logic                  w_got;
    logic [7:0]            awa;
    logic [31:0]           wda;
    logic [3:0]            wst;
  } eep_state_t;

endpackage : eep_pkg
`default_nettype wire

// [bench/eep_ctrl_monitor.sv]
// Checker for the serial EEPROM slave: pin timing, program pacing, register bus.
// Assumes the four-kilobit build, bound with the bench's shortened PROG_CYC.
`default_nettype none
module eep_ctrl_chk
  import eep_pkg::*;
#(
  parameter int unsigned PROG_CYC = PROG_BYTE_CYC
) (
  input wire logic         clk,
  input wire logic         rstn,
  input wire logic         scl_i,
  input wire logic         sda_oe,
  input wire logic         write_lock,
  input wire eep_arr_req_t arr_req,
  input wire eep_axi_req_t s_axi_req,
  input wire eep_axi_rsp_t s_axi_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap_r;
  logic        seen_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Cycles since the last array write; saturates so long idle never wraps
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else if (arr_req.we) begin
      gap_r  <= 16'h0001;
      seen_r <= 1'b1;
    end else if (gap_r != 16'hffff) begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  // Register bus takes
  sequence s_wr_take;
    s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
  endsequence
  sequence s_rd_take;
    s_axi_req.arvalid && s_axi_rsp.arready;
  endsequence
  a_oe_rise_low: assert property ($rose(sda_oe) |-> !scl_i)
    else $error("data pulled while clock high");
  a_oe_hold_high: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("data drive moved in clock high");
  a_we_single: assert property (arr_req.we |=> !arr_req.we)
    else $error("array strobe too long");
  a_we_spacing: assert property (arr_req.we && seen_r |-> gap_r >= 16'(PROG_CYC))
    else $error("array writes too close");
  // Margin of four cycles: busy may end slightly before PROG_CYC cycles after the last strobe
  a_busy_quiet: assert property (seen_r && gap_r < 16'(PROG_CYC) - 16'h0004 |-> !sda_oe)
    else $error("acknowledge while programming");
  a_we_lock: assert property (arr_req.we && write_lock |-> !arr_req.addr[8])
    else $error("protected half programmed");
  a_b_latency: assert property (s_wr_take |=> !s_axi_rsp.bvalid ##1 s_axi_rsp.bvalid)
    else $error("write response late");
  a_aw_block: assert property (s_axi_rsp.bvalid |-> !s_axi_rsp.awready && !s_axi_rsp.wready)
    else $error("write taken while answer pending");
  a_r_latency: assert property (s_rd_take |=> s_axi_rsp.rvalid && !s_axi_rsp.arready)
    else $error("read answer late");
endmodule : eep_ctrl_chk
bind eep_ctrl eep_ctrl_chk #(.PROG_CYC(PROG_CYC)) u_chk (.clk, .rstn, .scl_i, .sda_oe, .write_lock,
  .arr_req, .s_axi_req, .s_axi_rsp);
`default_nettype wire

// [bench/eep_host_model.sv]
// Host model of the two-wire bus: drives the clock, pulls the data wire low.
// Assumes the bench resolves the wire and returns its level on sda.
`default_nettype none
module eep_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic pull_low
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus: both lines high, clock still outside frames
  initial begin
    scl      = 1'b1;
    pull_low = 1'b0;
  end
  // Quarter of the 400 ns bus period
  task automatic q();
    repeat (2) @(posedge clk);
  endtask : q
  // Data falls with clock high; also a repeated start
  task automatic start();
    pull_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    pull_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask : start
  // Data rises with clock high to end the frame
  task automatic stop();
    pull_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    pull_low <= 1'b0;
    q();
    q();
  endtask : stop
  // Set in the low phase, sampled late in the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_low <= ~b;
    q();
    scl <= 1'b1;
    q();
    q();
    r = sda;
    scl <= 1'b0;
    q();
  endtask : bit_io
  // MSB first, then the acknowledge slot
  task automatic xbyte(input logic [7:0] d, input logic ack, output logic [7:0] rd, output logic got);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], rd[i]);
    end
    bit_io(ack, got);
  endtask : xbyte
endmodule : eep_host_model
`default_nettype wire

// [bench/eep_ctrl_bench.sv]
// Self-checking bench for the serial EEPROM slave, four-kilobit build.
// Assumes the host model and checker are compiled ahead of it.
`default_nettype none
module eep_ctrl_bench
  import eep_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned PCYC = 200;  // Short byte time keeps the run brief
  localparam logic [3:0]  DEVC = 4'h5; // Arbitrary device code
  logic         clk, rstn, scl, pull_low, sda_w, sda_o, sda_oe, wl;
  logic         junk_b;
  logic [7:0]   arr_rdata;
  eep_arr_req_t arr_req;
  eep_axi_req_t req;
  eep_axi_rsp_t rsp;
  logic [7:0]   mem [512];
  logic [7:0]   ref_m [512];
  int           bad_count, cmp_count, n;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda_w = ~(sda_oe | pull_low);
  // Cell array stand-in: data one cycle after address
  always @(posedge clk) begin
    if (arr_req.we) mem[arr_req.addr] <= arr_req.wdata;
    arr_rdata <= mem[arr_req.addr];
  end
  eep_ctrl #(.VARIANT(EEP_4K), .DEV_CODE(DEVC), .PROG_CYC(PCYC)) dut (
    .clk, .rstn, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe,
    .chip_sel_bit0(1'b1), .chip_sel_bit1(1'b1), .chip_sel_bit2(1'b0),
    .write_lock(wl), .arr_req, .arr_rdata, .s_axi_req(req), .s_axi_rsp(rsp));
  eep_host_model m (.clk, .sda(sda_w), .scl, .pull_low);
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_up();
    bad_count++;
    $display("ERROR t=%0t wait limit", $time);
    summarize();
  endtask : give_up
  task automatic note(input string s);
    $display("test %s done, %0d mismatches", s, bad_count);
  endtask : note
  function automatic logic [7:0] cb(input logic a0, input logic rd);
    return {DEVC, 2'b01, a0, rd};
  endfunction : cb
  // Register bus write; waits for the answer under a bound
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    req <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req <= '0;
    if (i == 40) give_up();
    chk(rsp.bresp, er);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk, input logic [1:0] er);
    int i;
    @(posedge clk);
    req <= '{1'b0, 8'h00, 1'b0, 32'h0, 4'h0, 1'b0, 1'b1, a, 1'b1};
    for (i = 0; i < 40; i++) begin
      @(posedge clk);
      if (rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    req <= '0;
    if (i == 40) give_up();
    chk({rsp.rresp, rsp.rdata & mk}, {er, ex});
  endtask : axi_rd
  task automatic wb(input logic [7:0] d, input logic e);
    logic [7:0] r;
    logic       a;
    m.xbyte(d, 1'b1, r, a);
    chk(a, e);
  endtask : wb
  // Poll with write control bytes until acknowledged
  task automatic poll(input logic a0, output int k);
    logic [7:0] r;
    logic       g;
    for (k = 0; k < 40; k++) begin
      m.start();
      m.xbyte(cb(a0, 1'b0), 1'b1, r, g);
      m.stop();
      if (g === 1'b0) break;
    end
    if (k == 40) give_up();
  endtask : poll
  // Optional pointer set, then read n bytes; the last one not acknowledged
  task automatic rd_seq(input logic [8:0] a, input int k, input logic set);
    logic [7:0] r;
    logic       g;
    if (set) begin
      m.start();
      wb(cb(a[8], 1'b0), 1'b0);
      wb(a[7:0], 1'b0);
    end
    m.start();
    wb(cb(a[8], 1'b1), 1'b0);
    for (int i = 0; i < k; i++) begin
      m.xbyte(8'hff, i == k - 1, r, g);
      chk(r, ref_m[a]);
      a = {a[8], a[7:0] + 8'h01};
    end
    chk(g, 1'b1);
    m.stop();
  endtask : rd_seq
  initial begin
    rstn = 1'b0;
    wl = 1'b0;
    req = '0;
    arr_rdata = 8'h00;
    junk_b = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    for (int i = 0; i < 512; i++) begin
      mem[i] = 8'(i * 7 + 1);
      ref_m[i] = 8'(i * 7 + 1);
    end
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    // Register block: reset value, unmapped place, read-only place, enable off
    axi_rd(8'h00, 32'h1, 32'hffffffff, RESP_OKAY);
    axi_rd(8'h08, 32'h0, 32'hffffffff, RESP_SLVERR);
    axi_wr(8'h04, 32'h0, RESP_SLVERR);
    axi_wr(8'h00, 32'h0, RESP_OKAY);
    m.start();
    wb(cb(1'b0, 1'b0), 1'b1);
    m.stop();
    axi_wr(8'h00, 32'h1, RESP_OKAY);
    note("regs");
    // Byte program, polling, then a current-address read
    m.start();
    wb(cb(1'b1, 1'b0), 1'b0);
    wb(8'h10, 1'b0);
    wb(8'ha5, 1'b0);
    m.stop();
    ref_m[9'h110] = 8'ha5;
    poll(1'b1, n);
    chk(n >= 1 && n <= 4, 1'b1);
    rd_seq(9'h111, 2, 1'b0);
    note("byte");
    // Ten bytes into an eight-byte page roll over
    m.start();
    wb(cb(1'b0, 1'b0), 1'b0);
    wb(8'h06, 1'b0);
    for (int k = 0; k < 10; k++) begin
      wb(8'h40 + 8'(k), 1'b0);
      ref_m[{6'h00, 3'(k + 6)}] = 8'h40 + 8'(k);
    end
    m.stop();
    axi_rd(8'h04, 32'h1, 32'h1, RESP_OKAY);
    poll(1'b0, n);
    chk(n >= 14 && n <= 24, 1'b1);
    rd_seq(9'h000, 8, 1'b1);
    note("page");
    // Protected upper half: data refused, nothing programmed
    wl <= 1'b1;
    m.start();
    wb(cb(1'b1, 1'b0), 1'b0);
    wb(8'h20, 1'b0);
    wb(8'h77, 1'b1);
    m.stop();
    poll(1'b1, n);
    chk(n, 0);
    wl <= 1'b0;
    note("lock");
    // Foreign chip and device codes, then a start inside a byte
    m.start();
    wb({DEVC, 2'b10, 1'b0, 1'b0}, 1'b1);
    m.start();
    wb({4'h6, 2'b01, 1'b0, 1'b0}, 1'b1);
    m.stop();
    m.start();
    for (int k = 0; k < 4; k++) begin
      m.bit_io(1'b1, junk_b);
    end
    rd_seq(9'h1fe, 3, 1'b1);
    rd_seq(9'h10f, 2, 1'b1);
    note("addr");
    summarize();
  end
endmodule : eep_ctrl_bench
`default_nettype wire
